// ==== rsm_pkg.sv ====
package rsm_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CAUSE = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_LEVEL = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  // Cause register fields
  localparam int CAUSE_WDT = 4;
  localparam int CAUSE_LV = 0;
  // Mode register fields
  localparam int MODE_RESET = 0;
  localparam int MODE_SOURCE = 1;
  localparam int MODE_ENABLE = 7;
  // Interrupt status fields
  localparam int IRQ_LV = 0;
  localparam int IRQ_LV_RESET = 1;
  localparam int IRQ_WDT = 2;
  localparam int IRQ_W = 3;
  localparam int LEVEL_W = 4;
  // Reset values
  localparam logic [7:0] CAUSE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_RST = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Startup sequencer states
  typedef enum logic [2:0] {
    ST_STRAP = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } rsm_state_e;
endpackage : rsm_pkg

// ==== rsm_det_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rsm_det_if;
  logic enable;
  logic reset_mode;
  logic source_select;
  logic supply_low;
  logic ext_low;
  logic lv_reset_req;
  logic lv_irq_evt;
  modport det (input enable, reset_mode, source_select, supply_low, ext_low, output lv_reset_req, lv_irq_evt);
  modport ctl (output enable, reset_mode, source_select, supply_low, ext_low, input lv_reset_req, lv_irq_evt);
endinterface : rsm_det_if
`default_nettype wire

// ==== rsm_detector.sv ====
`timescale 1ns/1ps
`default_nettype none
module rsm_detector (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Detector link
  rsm_det_if.det dif
);
  import rsm_pkg::*;
  logic sel_low;
  logic prev_low;
  logic prev_enable;
  // Source select picks supply or external sense comparator
  assign sel_low = dif.source_select ? dif.ext_low : dif.supply_low;
  // History for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_low <= 1'b0;
      prev_enable <= 1'b0;
    end else begin
      prev_low <= sel_low;
      prev_enable <= dif.enable;
    end
  end
  // Reset request is a level while the monitored input stays low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dif.lv_reset_req <= 1'b0;
    end else begin
      dif.lv_reset_req <= dif.enable && dif.reset_mode && sel_low;
    end
  end
  // Interrupt on falling input; disabling while low also fires, as the comparator output glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dif.lv_irq_evt <= 1'b0;
    end else begin
      dif.lv_irq_evt <= !dif.reset_mode && sel_low &&
                        ((dif.enable && !prev_low) || (prev_enable && !dif.enable));
    end
  end
endmodule : rsm_detector
`default_nettype wire

// ==== rsm_top.sv ====
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsm_top (
  // Clock and power-on-clear reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analogue, strap and watchdog inputs
  input wire logic detector_default_off,
  input wire logic supply_above_default,
  input wire logic supply_low,
  input wire logic external_sense_input,
  input wire logic wdt_overflow,
  // Reset and interrupt outputs
  output logic chip_reset,
  output logic wdt_reset,
  output logic irq
);
  import rsm_pkg::*;

  rsm_state_e state;
  logic [7:0] reset_cause_flags;
  logic detector_enable;
  logic detector_reset_mode;
  logic detector_source_select;
  logic [LEVEL_W-1:0] detector_level_reg;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic wr_go;
  logic rd_go;
  logic [31:0] next_rdata;
  logic rd_ok;
  logic wr_ok;
  logic cause_read;
  logic [IRQ_W-1:0] irq_evt;

  rsm_det_if dif ();
  rsm_detector u_det (
    .aclk(aclk),
    .aresetn(aresetn),
    .dif(dif)
  );
  assign dif.enable = detector_enable;
  assign dif.reset_mode = detector_reset_mode;
  assign dif.source_select = detector_source_select;
  assign dif.supply_low = supply_low;
  assign dif.ext_low = external_sense_input;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFS_CAUSE) || (a == OFS_MODE) || (a == OFS_LEVEL) ||
             (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) || (a == OFS_STATUS);
  endfunction : mapped

  // Handshake cycles of the bus
  assign wr_go = s_axi_awvalid && s_axi_awready;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign wr_ok = mapped(s_axi_awaddr) && s_axi_wstrb[0];
  assign rd_ok = mapped(s_axi_araddr);
  assign cause_read = rd_go && (s_axi_araddr == OFS_CAUSE);

  // Startup sequencer; strap is sampled one edge after release, never under reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_STRAP;
    end else begin
      case (state)
        ST_STRAP: begin
          state <= detector_default_off ? ST_RUN : ST_HOLD;
        end
        ST_HOLD: begin
          if (supply_above_default) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_STRAP;
        end
      endcase
    end
  end

  // Reset outputs toward the chip and the watchdog
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_reset <= 1'b1;
      wdt_reset <= 1'b1;
    end else begin
      chip_reset <= (state != ST_RUN) || dif.lv_reset_req || wdt_overflow;
      wdt_reset <= (state != ST_RUN) || dif.lv_reset_req || wdt_overflow;
    end
  end

  // Monitor setup; only the power-on-clear reset reaches it, never its own reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      detector_enable <= MODE_RST[MODE_ENABLE];
      detector_reset_mode <= MODE_RST[MODE_RESET];
      detector_source_select <= MODE_RST[MODE_SOURCE];
      detector_level_reg <= LEVEL_RST;
    end else if (state == ST_STRAP && !detector_default_off) begin
      // Default start runs the monitor in reset mode
      detector_enable <= 1'b1;
      detector_reset_mode <= 1'b1;
    end else if (wr_go && wr_ok && s_axi_awaddr == OFS_MODE) begin
      detector_enable <= s_axi_wdata[MODE_ENABLE];
      detector_reset_mode <= s_axi_wdata[MODE_RESET];
      detector_source_select <= s_axi_wdata[MODE_SOURCE];
    end else if (wr_go && wr_ok && s_axi_awaddr == OFS_LEVEL) begin
      // Upper bits are not stored, so a careless write cannot reach them
      detector_level_reg <= s_axi_wdata[LEVEL_W-1:0];
    end
  end

  // Cause flags; a new cause wins over the clearing read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_cause_flags <= CAUSE_RST;
    end else begin
      if (wdt_overflow) begin
        reset_cause_flags[CAUSE_WDT] <= 1'b1;
      end else if (cause_read) begin
        reset_cause_flags[CAUSE_WDT] <= 1'b0;
      end
      if (dif.lv_reset_req || (state == ST_HOLD && !supply_above_default)) begin
        reset_cause_flags[CAUSE_LV] <= 1'b1;
      end else if (cause_read) begin
        reset_cause_flags[CAUSE_LV] <= 1'b0;
      end
    end
  end

  // Interrupt events and write-one-to-clear status
  assign irq_evt = {wdt_overflow, dif.lv_reset_req, dif.lv_irq_evt};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_go && wr_ok && s_axi_awaddr == OFS_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~s_axi_wdata[IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat <= irq_stat | irq_evt;
      end
      if (wr_go && wr_ok && s_axi_awaddr == OFS_IRQ_MASK) begin
        irq_mask <= s_axi_wdata[IRQ_W-1:0];
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Write channel: address and data are taken together in one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_CAUSE: next_rdata[7:0] = reset_cause_flags;
      OFS_MODE: begin
        next_rdata[MODE_ENABLE] = detector_enable;
        next_rdata[MODE_RESET] = detector_reset_mode;
        next_rdata[MODE_SOURCE] = detector_source_select;
      end
      OFS_LEVEL: next_rdata[LEVEL_W-1:0] = detector_level_reg;
      OFS_IRQ_STAT: next_rdata[IRQ_W-1:0] = irq_stat;
      OFS_IRQ_MASK: next_rdata[IRQ_W-1:0] = irq_mask;
      OFS_STATUS: next_rdata[2:0] = {external_sense_input, supply_low, state == ST_RUN};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hold_until_good: assert property (state == ST_HOLD && !supply_above_default |=> chip_reset)
    else $error("reset released before supply good");
  a_cause_poc_zero: assert property ($rose(aresetn) |-> reset_cause_flags == CAUSE_RST)
    else $error("cause flags not clear after power-on-clear");
  a_wdt_self_reset: assert property (wdt_overflow |=> wdt_reset && chip_reset && reset_cause_flags[CAUSE_WDT])
    else $error("watchdog overflow did not reset watchdog");
  a_lv_keeps_setup: assert property (dif.lv_reset_req |=> $stable(detector_level_reg) && detector_enable)
    else $error("monitor reset disturbed monitor setup");
  a_lv_reset_chip: assert property (dif.lv_reset_req |=> chip_reset && reset_cause_flags[CAUSE_LV])
    else $error("monitor reset did not reach chip");
  a_default_flag: assert property (state == ST_HOLD && !supply_above_default |=> reset_cause_flags[CAUSE_LV])
    else $error("default start flag not set");
  a_cause_sticky: assert property (reset_cause_flags[CAUSE_WDT] && !cause_read |=> reset_cause_flags[CAUSE_WDT])
    else $error("watchdog cause lost without read");
  a_irq_flag_set: assert property (dif.lv_irq_evt |=> irq_stat[IRQ_LV])
    else $error("low voltage interrupt flag not set");
  a_irq_level: assert property (irq_stat[IRQ_LV] && irq_mask[IRQ_LV] |=> irq)
    else $error("unmasked flag did not raise interrupt");

  c_default_start: cover property (state == ST_HOLD ##[1:100] state == ST_RUN);
  c_wdt_reset: cover property (wdt_overflow ##1 wdt_reset);
  c_lv_irq: cover property (dif.lv_irq_evt ##2 irq);
  c_cause_read: cover property (cause_read && reset_cause_flags != 8'h00);
endmodule : rsm_top
`default_nettype wire

// ==== rsm_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rsm_pkg::*;
  // Bus, strap and analogue stimulus
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, mval;
  logic [3:0] wstrb, lv;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic dflt_off, supply_good, sup_low, ext_low, wdt_ovf;
  logic chip_reset, wdt_reset, irq;
  logic [7:0] ofs [5];
  int err_count, n_tests;

  rsm_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .detector_default_off(dflt_off), .supply_above_default(supply_good), .supply_low(sup_low),
    .external_sense_input(ext_low), .wdt_overflow(wdt_ovf), .chip_reset(chip_reset),
    .wdt_reset(wdt_reset), .irq(irq));

  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // Verdict and comparison helpers
  task give_verdict;
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  task hang(input string what);
    err_count++;
    $display("BAD %0t timeout %s", $time, what);
    give_verdict();
  endtask : hang

  // Write: both channels offered together, each released when taken
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int i;
    logic aw_ok, w_ok, b_ok;
    aw_ok = 0;
    w_ok = 0;
    b_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40 && !(aw_ok && w_ok); i++) begin
      @(posedge aclk);
      if (awready === 1'b1) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    if (!(aw_ok && w_ok)) hang("write address/data");
    for (i = 0; i < 40 && !b_ok; i++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) begin
        b_ok = 1;
        r = bresp;
        bready <= 1'b0;
      end
    end
    if (!b_ok) hang("write response");
  endtask : axi_wr

  // Read: returns data and response taken at the rvalid edge
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic a_ok, r_ok;
    a_ok = 0;
    r_ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40 && !a_ok; i++) begin
      @(posedge aclk);
      if (arready === 1'b1) begin
        a_ok = 1;
        arvalid <= 1'b0;
      end
    end
    if (!a_ok) hang("read address");
    for (i = 0; i < 40 && !r_ok; i++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) begin
        r_ok = 1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
    if (!r_ok) hang("read data");
  endtask : axi_rd

  task wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, 4'hf, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY}, "write resp");
  endtask : wr

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    axi_rd(a, rd, resp);
    check(rd, exp, what);
  endtask : rd_chk

  // Bounded wait on chip_reset (sel 0) or irq (sel 1)
  task wait_for(input int sel, input logic v);
    int i;
    for (i = 0; i < 30 && ((sel == 0) ? chip_reset : irq) !== v; i++) begin
      @(posedge aclk);
      #1;
    end
    if (((sel == 0) ? chip_reset : irq) !== v) hang("output level");
  endtask : wait_for

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, wdt_ovf, sup_low, ext_low} = 8'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    dflt_off = 1'b1;
    supply_good = 1'b1;
    aresetn = 1'b0;
    err_count = 0;
    n_tests = 0;
    ofs = '{OFS_CAUSE, OFS_MODE, OFS_LEVEL, OFS_IRQ_STAT, OFS_IRQ_MASK};
    void'($urandom(87024));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    wait_for(0, 1'b0);
    for (int k = 0; k < 5; k++) rd_chk(ofs[k], 32'h0, "reset value");
    rd_chk(OFS_STATUS, 32'h1, "status running");
    // Level field: corner values then random ones, upper bits kept zero
    for (int k = 0; k < 8; k++) begin
      lv = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom);
      wr(OFS_LEVEL, {28'h0, lv});
      rd_chk(OFS_LEVEL, {28'h0, lv}, "level");
    end
    // Refusals: unmapped place and a write without the low byte lane
    axi_wr(8'h18, 32'h5, 4'hf, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped write");
    axi_rd(8'h18, rd, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "unmapped read resp");
    check(rd, 32'h0, "unmapped read data");
    axi_wr(OFS_LEVEL, {28'h0, ~lv}, 4'he, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR}, "strobe refused");
    rd_chk(OFS_LEVEL, {28'h0, lv}, "level kept");
    // Watchdog overflow pulse
    @(posedge aclk);
    wdt_ovf <= 1'b1;
    @(posedge aclk);
    wdt_ovf <= 1'b0;
    #1;
    check({30'h0, chip_reset, wdt_reset}, 32'h3, "watchdog reset");
    rd_chk(OFS_CAUSE, 32'h1 << CAUSE_WDT, "watchdog cause");
    rd_chk(OFS_CAUSE, 32'h0, "cause cleared by read");
    rd_chk(OFS_IRQ_STAT, 32'h1 << IRQ_WDT, "watchdog event");
    wr(OFS_IRQ_MASK, 32'h1 << IRQ_WDT);
    wait_for(1, 1'b1);
    wr(OFS_IRQ_STAT, 32'h1 << IRQ_WDT);
    wait_for(1, 1'b0);
    wr(OFS_IRQ_MASK, 32'h0);
    // Monitor reset from each input source
    for (int src = 0; src < 2; src++) begin
      mval = (32'h1 << MODE_ENABLE) | (32'h1 << MODE_RESET) | (32'(src) << MODE_SOURCE);
      wr(OFS_MODE, 32'h0);
      wr(OFS_MODE, mval);
      @(posedge aclk);
      if (src == 0) sup_low <= 1'b1;
      else ext_low <= 1'b1;
      wait_for(0, 1'b1);
      check({31'h0, wdt_reset}, 32'h1, "watchdog held");
      @(posedge aclk);
      {sup_low, ext_low} <= 2'b00;
      wait_for(0, 1'b0);
      rd_chk(OFS_MODE, mval, "mode kept");
      rd_chk(OFS_LEVEL, {28'h0, lv}, "level kept");
      rd_chk(OFS_CAUSE, 32'h1 << CAUSE_LV, "monitor cause");
    end
    rd_chk(OFS_IRQ_STAT, 32'h1 << IRQ_LV_RESET, "monitor event");
    wr(OFS_IRQ_STAT, 32'h7);
    // Interrupt mode: clearing enable while the supply is low
    wr(OFS_MODE, 32'h0);
    @(posedge aclk);
    sup_low <= 1'b1;
    wr(OFS_MODE, 32'h1 << MODE_ENABLE);
    wr(OFS_IRQ_STAT, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1 << IRQ_LV);
    wr(OFS_MODE, 32'h0);
    wait_for(1, 1'b1);
    rd_chk(OFS_IRQ_STAT, 32'h1 << IRQ_LV, "disable event");
    rd_chk(OFS_STATUS, 32'h3, "status supply low");
    check({31'h0, chip_reset}, 32'h0, "no reset in irq mode");
    wr(OFS_IRQ_STAT, 32'h1 << IRQ_LV);
    wait_for(1, 1'b0);
    @(posedge aclk);
    sup_low <= 1'b0;
    // Default start: reset held until the supply is good
    @(posedge aclk);
    aresetn <= 1'b0;
    dflt_off <= 1'b0;
    supply_good <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (20) @(posedge aclk);
    #1;
    check({31'h0, chip_reset}, 32'h1, "startup hold");
    @(posedge aclk);
    supply_good <= 1'b1;
    wait_for(0, 1'b0);
    rd_chk(OFS_CAUSE, 32'h1 << CAUSE_LV, "default start flag");
    rd_chk(OFS_MODE, (32'h1 << MODE_ENABLE) | (32'h1 << MODE_RESET), "default mode");
    rd_chk(OFS_IRQ_MASK, 32'h0, "mask after reset");
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
